// ### shared/rtcaw_pkg.sv
package rtcaw_pkg;

  // ************************************************************
  // register map (byte addresses on the register port)
  // ************************************************************
  localparam int              RTCAW_AW        = 12;
  localparam logic [11:0]     ADDR_REPEAT     = 12'hF46;
  localparam logic [11:0]     ADDR_ALARM_CFG  = 12'hF47;
  localparam logic [11:0]     ADDR_AWIN_LOW   = 12'hF48;
  localparam logic [11:0]     ADDR_AWIN_HIGH  = 12'hF49;
  localparam logic [11:0]     ADDR_TWIN_LOW   = 12'hF4A;
  localparam logic [11:0]     ADDR_TWIN_HIGH  = 12'hF4B;
  localparam logic [11:0]     ADDR_TIME_CFG   = 12'hF4C;

  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int              CFG_ON_BIT      = 7;
  localparam int              CFG_CHIME_BIT   = 6;
  localparam int              CFG_IVL_LSB     = 2;
  localparam int              CFG_PTR_LSB     = 0;
  localparam int              TCFG_UNLOCK_BIT = 5;
  localparam int              TCFG_PTR_LSB    = 0;
  localparam logic [7:0]      REPEAT_RST      = 8'h00;
  localparam logic [7:0]      REPEAT_WRAP     = 8'hFF;
  localparam logic [7:0]      REPEAT_STEP     = 8'h01;
  localparam logic [1:0]      PTR_RST         = 2'h0;
  localparam logic [1:0]      PTR_FLOOR       = 2'h0;
  localparam logic [1:0]      PTR_STEP        = 2'h1;
  localparam logic [7:0]      CLOCK_RST       = 8'h00;
  localparam logic [7:0]      DATE_RST        = 8'h01;
  localparam logic [7:0]      READ_ZERO       = 8'h00;

  // ************************************************************
  // value fields: index, implemented bits
  // ************************************************************
  localparam int              N_TIME          = 7;
  localparam int              N_ALARM         = 6;
  typedef enum logic [2:0] {
    F_SEC   = 3'h0,
    F_MIN   = 3'h1,
    F_HOUR  = 3'h2,
    F_WEEKDAY_DIGIT  = 3'h3,
    F_DAY   = 3'h4,
    F_MONTH = 3'h5,
    F_YEAR  = 3'h6
  } rtcaw_field_t;
  localparam logic [7:0]      MASK_SEC        = 8'h7F;
  localparam logic [7:0]      MASK_MIN        = 8'h7F;
  localparam logic [7:0]      MASK_HOUR       = 8'h3F;
  localparam logic [7:0]      MASK_WEEKDAY_DIGIT       = 8'h07;
  localparam logic [7:0]      MASK_DAY        = 8'h3F;
  localparam logic [7:0]      MASK_MONTH      = 8'h1F;
  localparam logic [7:0]      MASK_YEAR       = 8'hFF;

  // window pointer positions
  localparam logic [1:0]      WP_MIN_SEC      = 2'h0;
  localparam logic [1:0]      WP_WEEKDAY_DIGIT_HOUR    = 2'h1;
  localparam logic [1:0]      WP_MONTH_DAY    = 2'h2;

  // alarm interval codes
  typedef enum logic [3:0] {
    IVL_HALF_SEC = 4'h0,
    IVL_SEC      = 4'h1,
    IVL_TEN_SEC  = 4'h2,
    IVL_MIN      = 4'h3,
    IVL_TEN_MIN  = 4'h4,
    IVL_HOUR     = 4'h5,
    IVL_DAY      = 4'h6,
    IVL_WEEK     = 4'h7,
    IVL_MONTH    = 4'h8,
    IVL_YEAR     = 4'h9
  } rtcaw_ivl_t;

endpackage

// ### hw/rtcaw_top.sv
`timescale 1ns/1ns

// Operation
// - after an alarm, drop alarm_on when repeat count is zero and chime off
// - with chime set, repeat count wraps from 00 to FF on the next alarm
// - with chime clear, repeat count holds at zero on later alarms
// - yearly alarm on February 29 fires only when that date occurs
// - alarm pointer steps down on each high window access, stops at zero
// - alarm pointer picks min/sec, weekday/hours, month/day, then nothing
// - repeat count gives the number of further alarms after the first
// - repeat count decrements on every alarm event while it is nonzero
// - year holds two BCD digits, tens high nibble, ones low nibble
// - month holds tens bit 4 and ones bits 3-0, bits 7-5 zero
// - day holds tens bits 5-4 and ones bits 3-0, bits 7-6 zero
// - weekday holds bits 2-0, values 0 to 6, upper bits zero
// - hours holds tens bits 5-4 and ones bits 3-0, bits 7-6 zero
// - minutes holds tens bits 6-4 and ones bits 3-0, bit 7 zero
// - seconds holds tens bits 6-4 and ones bits 3-0, bit 7 zero
// - date, weekday, hours and alarm date writes need the write unlock
// - alarm month and day use the time month and day layouts
// - time pointer steps down on each high window access, stops at zero
// - time pointer picks min/sec, weekday/hours, month/day, reserved/year
// - time window writes are dropped while the write unlock is clear
module rtcaw_top
  import rtcaw_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                rst,
  input  wire logic [RTCAW_AW-1:0] addr,
  input  wire logic [7:0]          wr_data,
  input  wire logic                wr_en,
  input  wire logic                rd_en,
  output logic      [7:0]          rd_data,
  input  wire logic                half_tick,
  input  wire logic                half_phase,
  input  wire logic                engine_wr,
  input  wire logic [2:0]          engine_sel,
  input  wire logic [7:0]          engine_data,
  output logic                     alarm_event,
  output logic                     alarm_on,
  output logic                     value_write_unlock,
  output logic      [1:0]          time_window_pointer
);

  // ************************************************************
  // decode helpers
  // ************************************************************

  // {valid, field} behind a window byte at a pointer position
  function automatic logic [3:0] win_field(input logic       hi,
                                           input logic [1:0] ptr,
                                           input logic       alarm);
    logic [2:0] f;
    logic       ok;
    f  = F_YEAR;
    ok = 1'b1;
    case (ptr)
      WP_MIN_SEC:   f = hi ? F_MIN : F_SEC;
      WP_WEEKDAY_DIGIT_HOUR: f = hi ? F_WEEKDAY_DIGIT : F_HOUR;
      WP_MONTH_DAY: f = hi ? F_MONTH : F_DAY;
      default:      ok = !hi && !alarm;
    endcase
    return {ok, f};
  endfunction

  // implemented bits of each value field; the rest always read zero
  function automatic logic [7:0] field_mask(input logic [2:0] idx);
    logic [7:0] m;
    m = MASK_YEAR;
    case (idx)
      F_SEC:   m = MASK_SEC;
      F_MIN:   m = MASK_MIN;
      F_HOUR:  m = MASK_HOUR;
      F_WEEKDAY_DIGIT:  m = MASK_WEEKDAY_DIGIT;
      F_DAY:   m = MASK_DAY;
      F_MONTH: m = MASK_MONTH;
      default: m = MASK_YEAR;
    endcase
    return m;
  endfunction

  function automatic logic [7:0] field_rst(input logic [2:0] idx);
    return (idx == F_DAY || idx == F_MONTH) ? DATE_RST : CLOCK_RST;
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  logic [7:0]  repeat_reg;
  logic        alarm_on_reg;
  logic        chime_reg;
  rtcaw_ivl_t  ivl_reg;
  logic [1:0]  aptr_reg;
  logic        unlock_reg;
  logic [1:0]  tptr_reg;
  logic [7:0]  tval_reg [0:N_TIME-1];
  logic [7:0]  aval_reg [0:N_ALARM-1];
  logic [7:0]  rd_data_reg;
  logic        alarm_event_reg;

  logic        sel_repeat;
  logic        sel_cfg;
  logic        sel_tcfg;
  logic        sel_awin;
  logic        sel_twin;
  logic        ahi_access;
  logic        thi_access;
  logic [3:0]  aw_fld;
  logic [3:0]  tw_fld;
  logic        t_wr;
  logic        a_wr;
  logic        fire;
  logic        match;
  logic [7:0]  cfg_view;
  logic [7:0]  tcfg_view;

  assign sel_repeat = (addr == ADDR_REPEAT);
  assign sel_cfg    = (addr == ADDR_ALARM_CFG);
  assign sel_tcfg   = (addr == ADDR_TIME_CFG);
  assign sel_awin   = (addr == ADDR_AWIN_LOW) || (addr == ADDR_AWIN_HIGH);
  assign sel_twin   = (addr == ADDR_TWIN_LOW) || (addr == ADDR_TWIN_HIGH);
  assign ahi_access = (wr_en || rd_en) && (addr == ADDR_AWIN_HIGH);
  assign thi_access = (wr_en || rd_en) && (addr == ADDR_TWIN_HIGH);
  assign aw_fld     = win_field(addr == ADDR_AWIN_HIGH, aptr_reg, 1'b1);
  assign tw_fld     = win_field(addr == ADDR_TWIN_HIGH, tptr_reg, 1'b0);

  // every time field is locked behind the unlock bit
  assign t_wr = wr_en && sel_twin && tw_fld[3] && unlock_reg;

  // alarm min/sec stay open; hours and everything above need the unlock
  assign a_wr = wr_en && sel_awin && aw_fld[3] &&
                (unlock_reg || (aw_fld[2:0] < F_HOUR));

  // ************************************************************
  // value storage
  // ************************************************************
  // a software write beats an engine load of the same field so that a
  // freshly set time is never overwritten by a stale carry
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < N_TIME; i++) begin
      if (rst) begin
        tval_reg[i] <= field_rst(3'(i));
      end else if (t_wr && tw_fld[2:0] == 3'(i)) begin
        tval_reg[i] <= wr_data & field_mask(3'(i));
      end else if (engine_wr && engine_sel == 3'(i)) begin
        tval_reg[i] <= engine_data & field_mask(3'(i));
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < N_ALARM; i++) begin
      if (rst) begin
        aval_reg[i] <= field_rst(3'(i));
      end else if (a_wr && aw_fld[2:0] == 3'(i)) begin
        aval_reg[i] <= wr_data & field_mask(3'(i));
      end
    end
  end

  // ************************************************************
  // alarm compare
  // ************************************************************
  always_comb begin
    logic sec_eq;
    logic sec_one_eq;
    logic min_eq;
    logic min_one_eq;
    logic hr_eq;
    logic wd_eq;
    logic day_eq;
    logic mon_eq;
    sec_eq     = tval_reg[F_SEC] == aval_reg[F_SEC];
    sec_one_eq = tval_reg[F_SEC][3:0] == aval_reg[F_SEC][3:0];
    min_eq     = tval_reg[F_MIN] == aval_reg[F_MIN];
    min_one_eq = tval_reg[F_MIN][3:0] == aval_reg[F_MIN][3:0];
    hr_eq      = tval_reg[F_HOUR] == aval_reg[F_HOUR];
    wd_eq      = tval_reg[F_WEEKDAY_DIGIT] == aval_reg[F_WEEKDAY_DIGIT];
    day_eq     = tval_reg[F_DAY] == aval_reg[F_DAY];
    mon_eq     = tval_reg[F_MONTH] == aval_reg[F_MONTH];
    case (ivl_reg)
      IVL_HALF_SEC: match = 1'b1;
      IVL_SEC:      match = 1'b1;
      IVL_TEN_SEC:  match = sec_one_eq;
      IVL_MIN:      match = sec_eq;
      IVL_TEN_MIN:  match = sec_eq && min_one_eq;
      IVL_HOUR:     match = sec_eq && min_eq;
      IVL_DAY:      match = sec_eq && min_eq && hr_eq;
      IVL_WEEK:     match = sec_eq && min_eq && hr_eq && wd_eq;
      IVL_MONTH:    match = sec_eq && min_eq && hr_eq && day_eq;
      // a full date compare only hits 02/29 in a leap year
      IVL_YEAR:     match = sec_eq && min_eq && hr_eq && day_eq &&
                            mon_eq;
      // reserved codes never fire rather than doing something odd
      default:      match = 1'b0;
    endcase
  end

  // only the half-second code fires on the mid-second tick
  assign fire = alarm_on_reg && half_tick && match &&
                (ivl_reg == IVL_HALF_SEC || !half_phase);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      alarm_event_reg <= 1'b0;
    end else begin
      alarm_event_reg <= fire;
    end
  end

  // ************************************************************
  // repeat counter
  // ************************************************************
  // a software write in the same cycle as an alarm wins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      repeat_reg <= REPEAT_RST;
    end else if (wr_en && sel_repeat) begin
      repeat_reg <= wr_data;
    end else if (fire) begin
      if (repeat_reg != REPEAT_RST) begin
        repeat_reg <= repeat_reg - REPEAT_STEP;
      end else if (chime_reg) begin
        repeat_reg <= REPEAT_WRAP;
      end else begin
        repeat_reg <= REPEAT_RST;
      end
    end
  end

  // ************************************************************
  // alarm configuration
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      alarm_on_reg <= 1'b0;
      chime_reg    <= 1'b0;
      ivl_reg      <= IVL_HALF_SEC;
      aptr_reg     <= PTR_RST;
    end else if (wr_en && sel_cfg) begin
      alarm_on_reg <= wr_data[CFG_ON_BIT];
      chime_reg    <= wr_data[CFG_CHIME_BIT];
      ivl_reg      <= rtcaw_ivl_t'(wr_data[CFG_IVL_LSB +: 4]);
      aptr_reg     <= wr_data[CFG_PTR_LSB +: 2];
    end else begin
      if (fire && repeat_reg == REPEAT_RST && !chime_reg) begin
        alarm_on_reg <= 1'b0;
      end
      if (ahi_access && aptr_reg != PTR_FLOOR) begin
        aptr_reg <= aptr_reg - PTR_STEP;
      end
    end
  end

  // ************************************************************
  // time window configuration
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      unlock_reg <= 1'b0;
      tptr_reg   <= PTR_RST;
    end else if (wr_en && sel_tcfg) begin
      unlock_reg <= wr_data[TCFG_UNLOCK_BIT];
      tptr_reg   <= wr_data[TCFG_PTR_LSB +: 2];
    end else if (thi_access && tptr_reg != PTR_FLOOR) begin
      tptr_reg <= tptr_reg - PTR_STEP;
    end
  end

  // ************************************************************
  // read port
  // ************************************************************
  always_comb begin
    cfg_view                       = READ_ZERO;
    cfg_view[CFG_ON_BIT]           = alarm_on_reg;
    cfg_view[CFG_CHIME_BIT]        = chime_reg;
    cfg_view[CFG_IVL_LSB +: 4]     = ivl_reg;
    cfg_view[CFG_PTR_LSB +: 2]     = aptr_reg;
    tcfg_view                      = READ_ZERO;
    tcfg_view[TCFG_UNLOCK_BIT]     = unlock_reg;
    tcfg_view[TCFG_PTR_LSB +: 2]   = tptr_reg;
  end

  // data stands for exactly the one cycle after the read strobe
  always_ff @(posedge sys_clk) begin
    if (rst || !rd_en) begin
      rd_data_reg <= READ_ZERO;
    end else if (sel_repeat) begin
      rd_data_reg <= repeat_reg;
    end else if (sel_cfg) begin
      rd_data_reg <= cfg_view;
    end else if (sel_tcfg) begin
      rd_data_reg <= tcfg_view;
    end else if (sel_twin && tw_fld[3]) begin
      rd_data_reg <= tval_reg[tw_fld[2:0]];
    end else if (sel_awin && aw_fld[3]) begin
      rd_data_reg <= aval_reg[aw_fld[2:0]];
    end else begin
      rd_data_reg <= READ_ZERO;
    end
  end

  assign rd_data             = rd_data_reg;
  assign alarm_event         = alarm_event_reg;
  assign alarm_on            = alarm_on_reg;
  assign value_write_unlock  = unlock_reg;
  assign time_window_pointer = tptr_reg;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  logic [8*N_TIME-1:0] tval_flat;
  logic [8*N_TIME-1:0] tmask_flat;
  always_comb begin
    for (int i = 0; i < N_TIME; i++) begin
      tval_flat[8*i +: 8]  = tval_reg[i];
      tmask_flat[8*i +: 8] = field_mask(3'(i));
    end
  end

  sequence s_alarm_hit;
    fire && !(wr_en && (sel_repeat || sel_cfg));
  endsequence

  sequence s_ahi_step;
    ahi_access && !(wr_en && sel_cfg) && aptr_reg != PTR_FLOOR;
  endsequence

  a_rpt_decrement: assert property (
    s_alarm_hit and (repeat_reg != REPEAT_RST)
    |=> repeat_reg == $past(repeat_reg) - REPEAT_STEP)
    else $error("repeat count did not step down on alarm");

  a_rpt_wrap: assert property (
    s_alarm_hit and (repeat_reg == REPEAT_RST && chime_reg)
    |=> repeat_reg == REPEAT_WRAP && alarm_on_reg)
    else $error("chime alarm did not wrap repeat count");

  a_rpt_hold_zero: assert property (
    s_alarm_hit and (repeat_reg == REPEAT_RST && !chime_reg)
    |=> repeat_reg == REPEAT_RST)
    else $error("repeat count left zero without chime");

  a_auto_disable: assert property (
    s_alarm_hit
    |=> alarm_on_reg == ($past(repeat_reg) != REPEAT_RST ||
                         $past(chime_reg)))
    else $error("alarm enable wrong after alarm event");

  a_event_cause: assert property (
    alarm_event_reg |-> $past(alarm_on_reg) && $past(half_tick))
    else $error("alarm event without enable and tick");

  a_aptr_step: assert property (
    s_ahi_step |=> aptr_reg == $past(aptr_reg) - PTR_STEP)
    else $error("alarm pointer did not step down");

  a_aptr_floor: assert property (
    ahi_access && aptr_reg == PTR_FLOOR |=> aptr_reg == PTR_FLOOR)
    else $error("alarm pointer went below zero");

  a_tptr_step: assert property (
    thi_access && !(wr_en && sel_tcfg) && tptr_reg != PTR_FLOOR
    |=> tptr_reg == $past(tptr_reg) - PTR_STEP)
    else $error("time pointer did not step down");

  a_locked_time: assert property (
    wr_en && sel_twin && !unlock_reg && !engine_wr |=> $stable(tval_flat))
    else $error("time value changed while locked");

  a_unused_zero: assert property (
    rd_en && sel_awin && !aw_fld[3] |=> rd_data_reg == READ_ZERO)
    else $error("unused alarm slot read nonzero");

  a_value_fields: assert property (
    (tval_flat & ~tmask_flat) == '0)
    else $error("unimplemented value bits set");

endmodule // rtcaw_top

// ### verif/rtcaw_tb_top.sv
`timescale 1ns/1ns
module rtcaw_tb_top;
  import rtcaw_pkg::*;
  logic                sys_clk, rst, wr_en, rd_en, half_tick, half_phase;
  logic                engine_wr, alarm_event, alarm_on, value_write_unlock;
  logic [RTCAW_AW-1:0] addr;
  logic [7:0]          wr_data, rd_data, engine_data, got;
  logic [2:0]          engine_sel;
  logic [1:0]          time_window_pointer;
  int                  mismatches, samples_checked, cycles;
  // op 1: interval a[3:0], phase a[4], expected event b[0]; op 0: load
  localparam logic [19:0] STEPS [0:29] = '{
    20'h00035, 20'h00110, 20'h00212, 20'h00303, 20'h00429, 20'h00502,
    20'h10201, 20'h10300, 20'h00025, 20'h10301, 20'h10401, 20'h10501,
    20'h10601, 20'h10701, 20'h10901, 20'h11100, 20'h10101, 20'h11001,
    20'h11600, 20'h00111, 20'h10400, 20'h10500, 20'h00110, 20'h00428,
    20'h10900, 20'h10800, 20'h00429, 20'h00503, 20'h10900, 20'h10801};
  localparam logic [7:0] TMASK [0:5] = '{8'h3F, 8'h1F, 8'h3F, 8'h07,
                                         8'h7F, 8'h7F};
  localparam logic [7:0] AVAL [0:5] = '{8'h29, 8'h02, 8'h12, 8'h03,
                                        8'h25, 8'h10};

  rtcaw_top i_dut (
    .sys_clk(sys_clk), .rst(rst), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .half_tick(half_tick), .half_phase(half_phase),
    .engine_wr(engine_wr), .engine_sel(engine_sel),
    .engine_data(engine_data), .alarm_event(alarm_event),
    .alarm_on(alarm_on), .value_write_unlock(value_write_unlock),
    .time_window_pointer(time_window_pointer));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // ************************************************************
  // bus and check helpers
  // ************************************************************
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp,
                     input logic [7:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge sys_clk);
    wr_en   <= 1'b0;
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rdc(input logic [11:0] a, input logic [7:0] exp,
                     input string nm);
    @(posedge sys_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1;
    got = rd_data;
    chk(nm, exp, got);
  endtask

  task automatic eng(input logic [2:0] sel, input logic [7:0] d);
    @(posedge sys_clk);
    engine_wr   <= 1'b1;
    engine_sel  <= sel;
    engine_data <= d;
    @(posedge sys_clk);
    engine_wr   <= 1'b0;
  endtask

  task automatic tick(input logic ph, input logic exp);
    @(posedge sys_clk);
    half_tick  <= 1'b1;
    half_phase <= ph;
    @(posedge sys_clk);
    half_tick  <= 1'b0;
    #1;
    chk("alarm_event", {7'h00, exp}, {7'h00, alarm_event});
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    rdc(ADDR_REPEAT, 8'h00, "repeat_reset");
    rdc(ADDR_ALARM_CFG, 8'h00, "cfg_reset");
    wr(12'hF45, 8'hA5);
    rdc(12'hF45, 8'h00, "unmapped");
    $display("test reset_values done");
  endtask

  task automatic t_time_win();
    wr(ADDR_TWIN_LOW, 8'h45);
    rdc(ADDR_TWIN_LOW, 8'h00, "sec_locked");
    wr(ADDR_TIME_CFG, 8'h23);
    chk("unlock", 8'h01, {7'h00, value_write_unlock});
    wr(ADDR_TWIN_LOW, 8'h99);
    rdc(ADDR_TWIN_LOW, 8'h99, "year");
    rdc(ADDR_TWIN_HIGH, 8'h00, "reserved");
    chk("time_ptr", 8'h02, {6'h00, time_window_pointer});
    for (int i = 0; i < 6; i++) begin
      wr(i[0] ? ADDR_TWIN_HIGH : ADDR_TWIN_LOW, 8'hFF);
    end
    chk("time_ptr", 8'h00, {6'h00, time_window_pointer});
    wr(ADDR_TIME_CFG, 8'h22);
    for (int i = 0; i < 6; i++) begin
      rdc(i[0] ? ADDR_TWIN_HIGH : ADDR_TWIN_LOW, TMASK[i],
          "tfield");
    end
    wr(ADDR_TIME_CFG, 8'h00);
    wr(ADDR_TWIN_LOW, 8'h12);
    rdc(ADDR_TWIN_LOW, 8'h7F, "sec_locked");
    $display("test time_window done");
  endtask

  task automatic t_alarm_win();
    wr(ADDR_ALARM_CFG, 8'h02);
    wr(ADDR_AWIN_LOW, 8'h15);
    rdc(ADDR_AWIN_LOW, 8'h01, "aday_locked");
    wr(ADDR_TIME_CFG, 8'h20);
    wr(ADDR_ALARM_CFG, 8'h03);
    wr(ADDR_AWIN_LOW, 8'h55);
    rdc(ADDR_AWIN_LOW, 8'h00, "unused_lo");
    rdc(ADDR_AWIN_HIGH, 8'h00, "unused_hi");
    rdc(ADDR_ALARM_CFG, 8'h02, "alarm_ptr");
    wr(ADDR_AWIN_LOW, 8'hFF);
    wr(ADDR_AWIN_HIGH, 8'hFF);
    wr(ADDR_ALARM_CFG, 8'h02);
    rdc(ADDR_AWIN_LOW, 8'h3F, "aday_mask");
    rdc(ADDR_AWIN_HIGH, 8'h1F, "amonth_mask");
    wr(ADDR_ALARM_CFG, 8'h02);
    for (int i = 0; i < 6; i++) begin
      wr(i[0] ? ADDR_AWIN_HIGH : ADDR_AWIN_LOW, AVAL[i]);
    end
    wr(ADDR_ALARM_CFG, 8'h02);
    for (int i = 0; i < 6; i++) begin
      rdc(i[0] ? ADDR_AWIN_HIGH : ADDR_AWIN_LOW, AVAL[i], "afield");
    end
    rdc(ADDR_AWIN_HIGH, 8'h10, "amin_again");
    rdc(ADDR_ALARM_CFG, 8'h00, "alarm_ptr_floor");
    $display("test alarm_window done");
  endtask

  task automatic t_repeat();
    wr(ADDR_REPEAT, 8'h02);
    wr(ADDR_ALARM_CFG, 8'h80);
    tick(1'b0, 1'b1);
    rdc(ADDR_REPEAT, 8'h01, "repeat");
    tick(1'b0, 1'b1);
    tick(1'b0, 1'b1);
    rdc(ADDR_REPEAT, 8'h00, "repeat_hold");
    chk("alarm_on", 8'h00, {7'h00, alarm_on});
    tick(1'b0, 1'b0);
    wr(ADDR_ALARM_CFG, 8'hC0);
    tick(1'b0, 1'b1);
    rdc(ADDR_REPEAT, 8'hFF, "repeat_wrap");
    chk("alarm_on", 8'h01, {7'h00, alarm_on});
    tick(1'b0, 1'b1);
    rdc(ADDR_REPEAT, 8'hFE, "repeat");
    $display("test repeat done");
  endtask

  task automatic t_intervals();
    for (int i = 0; i < 30; i++) begin
      if (STEPS[i][16]) begin
        wr(ADDR_ALARM_CFG, {2'h3, STEPS[i][11:8], 2'h0});
        tick(STEPS[i][12], STEPS[i][0]);
      end else begin
        eng(STEPS[i][10:8], STEPS[i][7:0]);
      end
    end
    $display("test intervals done");
  endtask

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      mismatches++;
      $display("CHECK FAILED timeout expected done seen hang");
      wrap_up();
    end
  end

  initial begin
    {rst, wr_en, rd_en, half_tick, half_phase, engine_wr} = 6'h20;
    addr = 12'h000;
    wr_data = 8'h00;
    engine_sel = 3'h0;
    engine_data = 8'h00;
    mismatches = 0;
    samples_checked = 0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_time_win();
    t_alarm_win();
    t_repeat();
    t_intervals();
    wrap_up();
  end
endmodule // rtcaw_tb_top
